// ===== rtl/spcmd_top.v
// Serial loader command interpreter with response timing in gear clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "spcmd_map.vh"
// Operation
// RULE1: host holds mode and reset low 10 ms
// RULE2: host waits 20 ms before first byte
// RULE3: echo sync byte after 660 gear cycles
// RULE4: echo baud byte after 540 gear cycles
// RULE5: echo operation command after 300 gear cycles
// RULE6: checksum over 32 KB takes 1493340 cycles
// RULE7: write data answer after 200 gear cycles
// RULE8: read data starts after 430 gear cycles
// RULE9: emulation setting echo after 420 gear cycles
// RULE10: security enable takes 1080 gear cycles
// RULE11: host waits 140 cycles after sync echo
// RULE12: host waits 90 cycles after baud echo
// RULE13: host waits 270 cycles after command echo
// RULE14: host waits 1100 cycles before next command
// RULE15: host waits 3 ms before end record
// RULE16: erase f0, write 30, read 40
// RULE17: checksum 90, id c0, status c3
// RULE18: all latencies counted in gear clock cycles
module spcmd_top #(
	parameter SUM_CYCLES = `SPCMD_DLY_SUM,
	parameter DATA_W = 8
) (
	input wire clk,
	input wire rst_n,
	input wire gear_tick,
	input wire mode_pin,
	input wire [DATA_W-1:0] rx_data,
	input wire rx_valid,
	output reg rx_ready,
	output reg [DATA_W-1:0] tx_data,
	output reg tx_valid,
	input wire tx_ready,
	input wire [DATA_W-1:0] mem_data,
	output reg [7:0] op_code,
	output reg op_start,
	output reg loader_busy,
	output reg secure_on,
	output reg cmd_error
);
	localparam [2:0] ST_SYNC = 3'h0;
	localparam [2:0] ST_BAUD = 3'h1;
	localparam [2:0] ST_CMD = 3'h2;
	localparam [2:0] ST_ARG = 3'h3;
	localparam [2:0] ST_WAIT = 3'h4;
	localparam [2:0] ST_SEND = 3'h5;
	localparam [2:0] ST_IDLE = 3'h6;
	localparam [2:0] ST_WORK = 3'h7;
	localparam [31:0] SUM_FULL = SUM_CYCLES;
	localparam [20:0] SUM_LEN = SUM_FULL[20:0];
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] after_reg;
	reg [2:0] after_next;
	reg [20:0] cnt_reg;
	reg [20:0] cnt_next;
	reg [7:0] resp_reg;
	reg [7:0] resp_next;
	reg [7:0] cmd_reg;
	reg [7:0] cmd_next;
	reg sec_next;
	reg err_next;
	reg start_next;
	reg rdy_next;
	reg busy_next;
	reg mode_s1_reg;
	reg mode_s2_reg;
	reg tick_s1_reg;
	reg tick_s2_reg;
	reg tick_s3_reg;
	wire tick;
	wire buf_in_ready;
	wire buf_out_valid;
	wire [DATA_W-1:0] buf_out_data;
	wire push;
	wire rx_take;
	wire tx_load;
	// Gear clock arrives from outside; edge taken after a two-stage sync
	always @(posedge clk) begin
		if (!rst_n) begin
			mode_s1_reg <= 1'b0;
			mode_s2_reg <= 1'b0;
			tick_s1_reg <= 1'b0;
			tick_s2_reg <= 1'b0;
			tick_s3_reg <= 1'b0;
		end else begin
			mode_s1_reg <= mode_pin;
			mode_s2_reg <= mode_s1_reg;
			tick_s1_reg <= gear_tick;
			tick_s2_reg <= tick_s1_reg;
			tick_s3_reg <= tick_s2_reg;
		end
	end
	assign tick = tick_s2_reg && !tick_s3_reg; // see RULE18
	assign push = (state_reg == ST_SEND) && buf_in_ready;
	assign rx_take = rx_valid && rx_ready;
	// Output stage refills only when empty or being taken, so a stall drops nothing
	assign tx_load = !tx_valid || tx_ready;
	spcmd_buf #(
		.W(DATA_W)
	) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.in_data(resp_reg),
		.out_valid(buf_out_valid),
		.out_ready(tx_load),
		.out_data(buf_out_data)
	);
	// Busy time in gear cycles of the long job run after its command echo
	function [20:0] op_delay;
		input [7:0] code;
		begin
			case (code)
				`SPCMD_OP_SUM: op_delay = SUM_LEN; // see RULE6
				`SPCMD_OP_SECURE: op_delay = 21'd`SPCMD_DLY_SECURE; // see RULE10
				default: op_delay = 21'd`SPCMD_DLY_OP; // see RULE5
			endcase
		end
	endfunction
	always @* begin
		state_next = state_reg;
		after_next = after_reg;
		cnt_next = cnt_reg;
		resp_next = resp_reg;
		cmd_next = cmd_reg;
		sec_next = secure_on;
		err_next = 1'b0;
		start_next = 1'b0;
		case (state_reg)
			ST_SYNC: begin
				if (rx_take) begin
					if (rx_data == `SPCMD_SYNC_BYTE) begin
						resp_next = rx_data;
						cnt_next = 21'd`SPCMD_DLY_SYNC; // see RULE3
						after_next = ST_BAUD;
						state_next = ST_WAIT;
					end else begin
						err_next = 1'b1;
					end
				end
			end
			ST_BAUD: begin
				if (rx_take) begin
					if (rx_data == `SPCMD_BAUD_BYTE) begin
						resp_next = rx_data;
						cnt_next = 21'd`SPCMD_DLY_BAUD; // see RULE4
						after_next = ST_CMD;
						state_next = ST_WAIT;
					end else begin
						err_next = 1'b1;
					end
				end
			end
			ST_CMD: begin
				if (rx_take) begin
					case (rx_data)
						`SPCMD_OP_ERASE, `SPCMD_OP_WRITE, `SPCMD_OP_READ,
						`SPCMD_OP_SUM, `SPCMD_OP_ID, `SPCMD_OP_STATUS,
						`SPCMD_OP_EMUL, `SPCMD_OP_SECURE: begin // see RULE16 see RULE17
							cmd_next = rx_data;
							resp_next = rx_data;
							start_next = 1'b1;
							cnt_next = 21'd`SPCMD_DLY_OP; // see RULE5
							if ((rx_data == `SPCMD_OP_ERASE) && secure_on) begin
								sec_next = 1'b0;
							end
							// Long jobs echo first, then run their own count
							if (rx_data == `SPCMD_OP_SUM || rx_data == `SPCMD_OP_SECURE) begin
								after_next = ST_WORK;
							end else if (rx_data == `SPCMD_OP_ID ||
								rx_data == `SPCMD_OP_STATUS ||
								rx_data == `SPCMD_OP_ERASE) begin
								after_next = ST_CMD;
							end else begin
								after_next = ST_ARG;
							end
							state_next = ST_WAIT;
						end
						default: begin
							err_next = 1'b1;
						end
					endcase
				end
			end
			ST_ARG: begin
				if (rx_take) begin
					after_next = ST_CMD;
					state_next = ST_WAIT;
					if (cmd_reg == `SPCMD_OP_WRITE) begin
						resp_next = rx_data;
						cnt_next = 21'd`SPCMD_DLY_WRITE; // see RULE7
						after_next = ST_ARG;
					end else if (cmd_reg == `SPCMD_OP_READ) begin
						resp_next = mem_data;
						cnt_next = 21'd`SPCMD_DLY_READ; // see RULE8
					end else begin
						resp_next = rx_data;
						cnt_next = 21'd`SPCMD_DLY_EMUL; // see RULE9
					end
				end
			end
			ST_WAIT: begin
				if (tick) begin
					if (cnt_reg <= 21'd1) begin
						state_next = ST_SEND;
					end else begin
						cnt_next = cnt_reg - 21'd1;
					end
				end
			end
			ST_SEND: begin
				if (push) begin
					state_next = after_reg;
					if (after_reg == ST_WORK) begin
						cnt_next = op_delay(cmd_reg);
					end
				end
			end
			// Checksum or security job: busy for its own count, no answer byte
			ST_WORK: begin
				if (tick) begin
					if (cnt_reg <= 21'd1) begin
						state_next = ST_CMD;
						if (cmd_reg == `SPCMD_OP_SECURE) begin
							sec_next = 1'b1; // see RULE10
						end
					end else begin
						cnt_next = cnt_reg - 21'd1;
					end
				end
			end
			ST_IDLE: begin
				if (mode_s2_reg) begin
					state_next = ST_SYNC;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (!mode_s2_reg) begin
			state_next = ST_IDLE;
		end
	end
	// Handshake levels follow the state being entered
	always @* begin
		rdy_next = 1'b0;
		busy_next = 1'b0;
		case (state_next)
			ST_SYNC, ST_BAUD, ST_CMD, ST_ARG: begin
				rdy_next = 1'b1;
			end
			ST_WAIT, ST_SEND, ST_WORK: begin
				busy_next = 1'b1;
			end
			default: begin
				rdy_next = 1'b0;
			end
		endcase
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			after_reg <= ST_SYNC;
			cnt_reg <= 21'h000000;
			resp_reg <= 8'h00;
			cmd_reg <= 8'h00;
			secure_on <= 1'b0;
			cmd_error <= 1'b0;
			op_start <= 1'b0;
			op_code <= 8'h00;
			rx_ready <= 1'b0;
			loader_busy <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			state_reg <= state_next;
			after_reg <= after_next;
			cnt_reg <= cnt_next;
			resp_reg <= resp_next;
			cmd_reg <= cmd_next;
			secure_on <= sec_next;
			cmd_error <= err_next;
			op_start <= start_next;
			op_code <= cmd_next;
			rx_ready <= rdy_next;
			loader_busy <= busy_next;
			if (tx_load) begin
				tx_valid <= buf_out_valid;
				tx_data <= buf_out_data;
			end
		end
	end
endmodule // spcmd_top
`default_nettype wire

// ===== rtl/spcmd_map.vh
// Constants for the serial loader command timing block
`ifndef SPCMD_MAP_VH
`define SPCMD_MAP_VH
`define SPCMD_SYNC_BYTE 8'h86
`define SPCMD_BAUD_BYTE 8'h79
`define SPCMD_OP_ERASE 8'hf0
`define SPCMD_OP_WRITE 8'h30
`define SPCMD_OP_READ 8'h40
`define SPCMD_OP_SUM 8'h90
`define SPCMD_OP_ID 8'hc0
`define SPCMD_OP_STATUS 8'hc3
`define SPCMD_OP_EMUL 8'hd0
`define SPCMD_OP_SECURE 8'hd8
`define SPCMD_DLY_SYNC 660
`define SPCMD_DLY_BAUD 540
`define SPCMD_DLY_OP 300
`define SPCMD_DLY_SUM 1493340
`define SPCMD_DLY_WRITE 200
`define SPCMD_DLY_READ 430
`define SPCMD_DLY_EMUL 420
`define SPCMD_DLY_SECURE 1080
`define SPCMD_GAP_SYNC 140
`define SPCMD_GAP_BAUD 90
`define SPCMD_GAP_OP 270
`define SPCMD_GAP_NEXT 1100
`define SPCMD_CNT_W 21
`endif

// ===== rtl/spcmd_buf.v
// Two-entry skid buffer for the response byte stream
`timescale 1ns/1ps
`default_nettype none
module spcmd_buf #(
	parameter W = 8
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem_reg [0:1];
	reg wptr_reg;
	reg rptr_reg;
	reg [1:0] cnt_reg;
	wire push;
	wire pop;
	assign in_ready = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = mem_reg[rptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always @(posedge clk) begin
		if (push) begin
			mem_reg[wptr_reg] <= in_data;
		end
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (push) begin
				wptr_reg <= ~wptr_reg;
			end
			if (pop) begin
				rptr_reg <= ~rptr_reg;
			end
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // spcmd_buf
`default_nettype wire

// ===== testbench/spcmd_checker.sv
// Port assertions for the loader command block
`timescale 1ns/1ps
`default_nettype none
module spcmd_checker (
	input wire clk,
	input wire rst_n,
	input wire rx_valid,
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_ready,
	input wire [7:0] op_code,
	input wire op_start,
	input wire loader_busy,
	input wire cmd_error
);
	default clocking dck @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_take;
		rx_valid && rx_ready;
	endsequence
	sequence s_quiet;
		!tx_valid [*8];
	endsequence
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	property p_take; s_take |=> cmd_error || (!rx_ready && loader_busy); endproperty
	property p_keep; cmd_error |-> rx_ready; endproperty
	property p_wait; s_take |=> s_quiet; endproperty
	property p_op; op_start |=> !op_start; endproperty
	property p_err; cmd_error |=> !cmd_error; endproperty
	property p_code;
		op_start |-> op_code inside {8'hf0, 8'h30, 8'h40, 8'h90, 8'hc0, 8'hc3, 8'hd0, 8'hd8};
	endproperty
	property p_ready; loader_busy |-> !rx_ready; endproperty
	property p_rise; $rose(tx_valid) |-> $past(loader_busy, 2); endproperty
	a_hold: assert property (p_hold) else $error("tx byte lost");
	a_take: assert property (p_take) else $error("take not closed");
	a_wait: assert property (p_wait) else $error("answer too early");
	a_op: assert property (p_op) else $error("op_start long");
	a_err: assert property (p_err) else $error("cmd_error long");
	a_code: assert property (p_code) else $error("bad op_code");
	a_ready: assert property (p_ready) else $error("ready while busy");
	a_rise: assert property (p_rise) else $error("tx while idle");
	a_keep: assert property (p_keep) else $error("bad byte left receive state");
endmodule // spcmd_checker
bind spcmd_top spcmd_checker u_chk (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.op_code(op_code), .op_start(op_start), .loader_busy(loader_busy), .cmd_error(cmd_error));
`default_nettype wire

// ===== testbench/spcmd_host.sv
// Host model: gear clock source and answer receiver
`timescale 1ns/1ps
`default_nettype none
module spcmd_host (
	input wire clk,
	input wire stall,
	input wire tx_valid,
	input wire [7:0] tx_data,
	output reg gear_tick = 1'b0,
	output reg tx_ready = 1'b0,
	output reg [7:0] got_byte = 8'h00
);
	reg [1:0] div_reg = 2'h0;
	always @(posedge clk) begin
		div_reg <= div_reg + 2'h1;
		if (div_reg[0])
			gear_tick <= !gear_tick;
		tx_ready <= !stall;
		if (tx_valid && tx_ready)
			got_byte <= tx_data;
	end
endmodule // spcmd_host
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the loader command block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	reg clk = 0, rst_n = 0, mode_pin = 0, rx_valid = 0, stall = 0;
	reg [7:0] rx_data = 8'h00, mem_data = 8'h5a;
	reg [39:0] codes = 40'hf0d890c3c0;
	wire gear_tick, rx_ready, tx_valid, tx_ready, op_start, loader_busy, secure_on, cmd_error;
	wire [7:0] tx_data, op_code, got_byte;
	integer errors = 0, total_checks = 0, ticks = 0, nerr = 0, nops = 0, t0 = 0, i, k, t;
	spcmd_top #(.SUM_CYCLES(20)) u_dut (.clk(clk), .rst_n(rst_n), .gear_tick(gear_tick),
		.mode_pin(mode_pin), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .mem_data(mem_data),
		.op_code(op_code), .op_start(op_start), .loader_busy(loader_busy),
		.secure_on(secure_on), .cmd_error(cmd_error));
	spcmd_host u_host (.clk(clk), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
		.gear_tick(gear_tick), .tx_ready(tx_ready), .got_byte(got_byte));
	initial begin
		forever #4 clk = !clk;
	end
	always @(posedge gear_tick) ticks = ticks + 1;
	always @(posedge clk) if (cmd_error === 1'b1) nerr = nerr + 1;
	always @(posedge clk) if (op_start === 1'b1) nops = nops + 1;
	task end_of_test;
		begin
			$display("errors %0d checks %0d", errors, total_checks);
			if (errors == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("[FAIL] %0t mismatch %0h %0h", $time, seen, exp);
			end
		end
	endtask
	task tmo;
		begin
			check(0, 1);
			end_of_test;
		end
	endtask
	task put(input [7:0] b);
		begin
			rx_data <= b;
			rx_valid <= 1'b1;
			stall <= 1'b1;
			@(negedge clk);
			for (i = 0; rx_ready !== 1'b1; i = i + 1) begin
				if (i > 20000) tmo;
				@(negedge clk);
			end
			@(posedge clk);
			t0 = ticks;
			rx_valid <= 1'b0;
		end
	endtask
	// Answer byte, its delay in gear ticks, then the host takes it
	task echo(input [8:0] exp, input integer n);
		begin
			for (i = 0; tx_valid !== 1'b1; i = i + 1) begin
				if (i > 20000) tmo;
				@(negedge clk);
			end
			k = ticks - t0;
			t0 = ticks;
			check(k >= n - 1 && k <= n + 2, 1);
			if (!exp[8]) check(tx_data, exp[7:0]);
			@(posedge clk);
			stall <= 1'b0;
			repeat (3) @(negedge clk);
			if (!exp[8]) check(got_byte, exp[7:0]);
			@(posedge clk);
		end
	endtask
	// Busy time of a long job, counted from its echo
	task work(input integer n);
		begin
			for (i = 0; loader_busy !== 1'b0; i = i + 1) begin
				if (i > n * 9 + 20) tmo;
				@(negedge clk);
			end
			k = ticks - t0;
			check(k >= n - 2 && k <= n + 1, 1);
			@(posedge clk);
		end
	endtask
	task gap(input integer n);
		begin
			k = ticks + n;
			for (i = 0; ticks < k; i = i + 1) begin
				if (i > n * 9 + 9) tmo;
				@(posedge clk);
			end
		end
	endtask
	task sc_refuse;
		begin
			check(rx_ready, 0);
			mode_pin <= 1'b1;
			gap(20);
			put(8'h55);
			repeat (50) @(posedge clk);
			check(nerr, 1);
			check(tx_valid, 0);
		end
	endtask
	task sc_sync;
		begin
			put(8'h86);
			echo(9'h086, 660);
			gap(150);
			put(8'h79);
			echo(9'h079, 540);
			gap(100);
		end
	endtask
	task sc_cmds;
		begin
			for (t = 0; t < 5; t = t + 1) begin
				put(codes[8*t +: 8]);
				echo({1'b0, codes[8*t +: 8]}, 300);
				check(op_code, codes[8*t +: 8]);
				if (codes[8*t +: 8] == 8'h90) work(20);
				if (codes[8*t +: 8] == 8'hd8) work(1080);
				gap(1200);
				check(secure_on, codes[8*t +: 8] == 8'hd8);
			end
			check(nops, 5);
		end
	endtask
	task sc_data;
		begin
			put(8'h40);
			echo(9'h040, 300);
			gap(280);
			put(8'h01);
			echo(9'h05a, 430);
			gap(1200);
			put(8'hd0);
			echo(9'h0d0, 300);
			gap(280);
			put(8'h3c);
			echo(9'h03c, 420);
			gap(1200);
			put(8'h30);
			echo(9'h030, 300);
			gap(280);
			put(8'h3a);
			echo(9'h100, 200);
			gap(3000);
			put(8'h3a);
			echo(9'h100, 200);
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		sc_refuse;
		sc_sync;
		sc_cmds;
		sc_data;
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
